// >>> logic_ops.sv
// register-driven two-input and eight-input configurable logic operators
//
// Operation
// - numeric below 0.5 low, else high; boolean out
// - each dual input invertible before the AND, OR, XOR and latch operations
// - dual AND high only when both high
// - dual OR high when either high
// - dual XOR high when exactly one high
// - equal high when operand values identical
// - not-equal high when operand values differ
// - greater-than and less-than strict value compare
// - at-most and at-least non-strict value compare
// - latch follows first while second high, else captures
// - bad operand status applies fallback result and status
// - four fallback policies: low/high with faulty/healthy
// - compare hysteresis holds result until band left
// - octal gate uses two to eight active inputs
// - octal AND high when all active inputs high
// - octal OR high when any active input high
// - octal XOR high on odd count of highs
// - octal status word ORs active input status bits
// - per-input negate mask, bit 0 is input one
// - octal output negate gives NAND and NOR
// - octal selector: AND, OR, XOR or off
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps

module logic_ops (
   // clock and reset
   input  wire logic                                i_clk,
   input  wire logic                                i_rst,

   // register port
   input  wire logic [logic_ops_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic [logic_ops_pkg::DATA_W-1:0]    i_wdata,
   input  wire logic                                i_wr,
   input  wire logic                                i_rd,
   output logic      [logic_ops_pkg::DATA_W-1:0]    o_rdata,

   // dual input gate result
   output logic                                     o_dual_result,
   output logic                                     o_dual_status_bad,

   // octal input gate result
   output logic                                     o_octal_result,
   output logic      [logic_ops_pkg::NUM_IN:0]      o_octal_status
);
   import logic_ops_pkg::*;

   typedef struct packed {
      // configuration and operands, written over the register port
      dual_cfg_t             dcfg;
      operand_t              first_operand;
      operand_t              second_operand;
      logic [VAL_W-1:0]      hyst;
      octal_cfg_t            ocfg;
      logic [NUM_IN-1:0]     olevel;
      logic [NUM_IN-1:0]     obad;

      // dual gate result and its memory
      logic                  dres;
      logic                  dbad;
      logic                  dhold;
      logic                  darmed;
      logic                  aprev;

      // octal gate result
      logic                  ores;
      logic [NUM_IN:0]       ostat;

      // registered read word
      logic [DATA_W-1:0]     rdata;
   } state_t;

   state_t q_ff;
   state_t nxt_q;

   // threshold a numeric operand at one half, then apply its invert
   function automatic logic to_level(input logic signed [VAL_W-1:0] v, input logic inv);
      to_level = (v >= LOGIC_HALF) ^ inv;
   endfunction

   // counts outside two to eight are clamped rather than refused
   function automatic logic [3:0] clamp_count(input logic [3:0] cnt);
      clamp_count = cnt;
      if (cnt < OCT_MIN_IN) begin
         clamp_count = OCT_MIN_IN;
      end
      if (cnt > OCT_MAX_IN) begin
         clamp_count = OCT_MAX_IN;
      end
   endfunction

   // active-input mask, bit 0 is input one
   function automatic logic [NUM_IN-1:0] active_mask(input logic [3:0] cnt);
      for (int i = 0; i < NUM_IN; i++) begin
         active_mask[i] = (4'(i) < clamp_count(cnt));
      end
   endfunction

   // upper-side hold: set until the first operand falls below the lower band edge;
   // a zero band gives no hold, so the strict compares stay strict
   function automatic logic keep_above(input logic                    held,
                                       input logic [VAL_W-1:0]        band,
                                       input logic signed [VAL_W+1:0] a,
                                       input logic signed [VAL_W+1:0] lim);
      keep_above = held && (band != '0) && !(a < lim);
   endfunction

   // lower-side hold: set until the first operand rises above the upper band edge
   function automatic logic keep_below(input logic                    held,
                                       input logic [VAL_W-1:0]        band,
                                       input logic signed [VAL_W+1:0] a,
                                       input logic signed [VAL_W+1:0] lim);
      keep_below = held && (band != '0) && !(a > lim);
   endfunction

   // forced {status bad, result} of each fallback policy
   function automatic logic [1:0] fallback_word(input fallback_t pol);
      case (pol)
         POLICY_LOW_FAULTY: begin
            fallback_word = 2'h2;
         end
         POLICY_HIGH_FAULTY: begin
            fallback_word = 2'h3;
         end
         POLICY_LOW_HEALTHY: begin
            fallback_word = 2'h0;
         end
         POLICY_HIGH_HEALTHY: begin
            fallback_word = 2'h1;
         end
         default: begin
            fallback_word = 2'h2;
         end
      endcase
   endfunction

   logic                  a_lvl;
   logic                  b_lvl;
   logic signed [VAL_W+1:0] a_ext;
   logic signed [VAL_W+1:0] b_ext;
   logic signed [VAL_W+1:0] b_minus_h;
   logic signed [VAL_W+1:0] b_plus_h;

   logic                  cmp_raw;
   logic                  cmp_keep;
   logic                  dual_calc;
   logic [NUM_IN-1:0]     omask;
   logic [NUM_IN-1:0]     olv;
   logic                  oct_calc;

   always_comb begin
      nxt_q = q_ff;

      // register writes
      if (i_wr) begin
         case (i_addr)
            A_DUAL_CFG: begin
               nxt_q.dcfg = dual_cfg_t'(i_wdata[$bits(dual_cfg_t)-1:0]);
            end

            A_DUAL_OPA: begin
               nxt_q.first_operand = operand_t'(i_wdata[F_OPD_BAD:0]);
            end

            A_DUAL_OPB: begin
               nxt_q.second_operand = operand_t'(i_wdata[F_OPD_BAD:0]);
            end

            A_DUAL_HYST: begin
               nxt_q.hyst = i_wdata[VAL_W-1:0];
            end

            A_OCT_CFG: begin
               nxt_q.ocfg = octal_cfg_t'(i_wdata[$bits(octal_cfg_t)-1:0]);
            end

            A_OCT_IN: begin
               nxt_q.olevel = i_wdata[NUM_IN-1:0];
               nxt_q.obad   = i_wdata[F_OCT_BAD +: NUM_IN];
            end

            // read-only and unmapped addresses ignore writes
            default: begin
            end
         endcase
      end

      // dual gate, evaluated every cycle from the stored configuration
      a_lvl     = to_level(q_ff.first_operand.value, q_ff.dcfg.inv_a);
      b_lvl     = to_level(q_ff.second_operand.value, q_ff.dcfg.inv_b);
      a_ext     = {{2{q_ff.first_operand.value[VAL_W-1]}}, q_ff.first_operand.value};
      b_ext     = {{2{q_ff.second_operand.value[VAL_W-1]}}, q_ff.second_operand.value};
      // 18-bit arithmetic: a full-scale band around a full-scale operand
      // still fits, so the band edges never wrap
      b_minus_h = b_ext - $signed({2'h0, q_ff.hyst});
      b_plus_h  = b_ext + $signed({2'h0, q_ff.hyst});
      cmp_raw   = 1'b0;
      cmp_keep  = 1'b0;
      dual_calc = 1'b0;
      // previous first level feeds the latch edge detector
      nxt_q.aprev = a_lvl;
      case (q_ff.dcfg.op)
         D_OFF: begin
            dual_calc = 1'b0;
         end

         D_AND: begin
            dual_calc = a_lvl & b_lvl;
         end

         D_OR: begin
            dual_calc = a_lvl | b_lvl;
         end

         D_XOR: begin
            dual_calc = a_lvl ^ b_lvl;
         end

         D_LATCH: begin
            // a capture disarms the latch until the second operand is high again
            dual_calc = q_ff.dres;
            if (b_lvl) begin
               dual_calc    = a_lvl;
               nxt_q.darmed = 1'b1;
            end else if (q_ff.darmed && (a_lvl != q_ff.aprev)) begin
               dual_calc    = a_lvl;
               nxt_q.darmed = 1'b0;
            end
         end

         D_EQ: begin
            dual_calc = (a_ext == b_ext);
         end

         D_NE: begin
            dual_calc = (a_ext != b_ext);
         end

         D_GT: begin
            cmp_raw   = (a_ext > b_ext);
            cmp_keep  = keep_above(q_ff.dhold, q_ff.hyst, a_ext, b_minus_h);
            dual_calc = cmp_raw | cmp_keep;
         end

         D_LT: begin
            cmp_raw   = (a_ext < b_ext);
            cmp_keep  = keep_below(q_ff.dhold, q_ff.hyst, a_ext, b_plus_h);
            dual_calc = cmp_raw | cmp_keep;
         end

         D_LE: begin
            cmp_raw   = (a_ext <= b_ext);
            cmp_keep  = keep_below(q_ff.dhold, q_ff.hyst, a_ext, b_plus_h);
            dual_calc = cmp_raw | cmp_keep;
         end

         D_GE: begin
            cmp_raw   = (a_ext >= b_ext);
            cmp_keep  = keep_above(q_ff.dhold, q_ff.hyst, a_ext, b_minus_h);
            dual_calc = cmp_raw | cmp_keep;
         end

         // unused codes act as off
         default: begin
            dual_calc = 1'b0;
         end
      endcase
      // hysteresis memory is only meaningful for the ordering compares
      nxt_q.dhold = (q_ff.dcfg.op inside {D_GT, D_LT, D_LE, D_GE}) ? dual_calc : 1'b0;
      if (q_ff.dcfg.op != D_LATCH && q_ff.dcfg.op != D_OFF) begin
         nxt_q.darmed = 1'b0;
      end
      if (q_ff.first_operand.bad || q_ff.second_operand.bad) begin
         {nxt_q.dbad, nxt_q.dres} = fallback_word(q_ff.dcfg.fallback);
      end else begin
         nxt_q.dres = dual_calc;
         nxt_q.dbad = 1'b0;
      end

      // octal gate
      omask = active_mask(q_ff.ocfg.count);
      olv   = (q_ff.olevel ^ q_ff.ocfg.per_input_negate_mask) & omask;
      case (q_ff.ocfg.op)
         O_AND: begin
            oct_calc = &(olv | ~omask);
         end

         O_OR: begin
            oct_calc = |olv;
         end

         O_XOR: begin
            oct_calc = ^olv;
         end

         default: begin
            oct_calc = 1'b0;
         end
      endcase
      // off stays low even with output negate set
      nxt_q.ores  = (q_ff.ocfg.op == O_OFF) ? 1'b0 : (oct_calc ^ q_ff.ocfg.out_negate);
      nxt_q.ostat = {|(q_ff.obad & omask), q_ff.obad & omask};

      // read data stands only in the cycle after the strobe
      nxt_q.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            A_DUAL_CFG: begin
               nxt_q.rdata[$bits(dual_cfg_t)-1:0] = q_ff.dcfg;
            end

            A_DUAL_OPA: begin
               nxt_q.rdata[F_OPD_BAD:0] = q_ff.first_operand;
            end

            A_DUAL_OPB: begin
               nxt_q.rdata[F_OPD_BAD:0] = q_ff.second_operand;
            end

            A_DUAL_HYST: begin
               nxt_q.rdata[VAL_W-1:0] = q_ff.hyst;
            end

            A_DUAL_OUT: begin
               nxt_q.rdata[0]         = q_ff.dres;
               nxt_q.rdata[F_OUT_BAD] = q_ff.dbad;
            end

            A_OCT_CFG: begin
               nxt_q.rdata[$bits(octal_cfg_t)-1:0] = q_ff.ocfg;
            end

            A_OCT_IN: begin
               nxt_q.rdata[NUM_IN-1:0]          = q_ff.olevel;
               nxt_q.rdata[F_OCT_BAD +: NUM_IN] = q_ff.obad;
            end

            // results as they stand at the read edge
            A_OCT_OUT: begin
               nxt_q.rdata[0]                      = q_ff.ores;
               nxt_q.rdata[F_OUT_ANYBAD]           = q_ff.ostat[NUM_IN];
               nxt_q.rdata[F_OUT_STAT +: NUM_IN]   = q_ff.ostat[NUM_IN-1:0];
            end

            default: begin
               nxt_q.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         // whole state cleared, then configuration takes its reset values
         q_ff                <= '0;
         q_ff.dcfg           <= DUAL_CFG_RST;
         q_ff.first_operand  <= OPERAND_RST;
         q_ff.second_operand <= OPERAND_RST;
         q_ff.hyst           <= HYST_RST;
         q_ff.ocfg           <= OCT_CFG_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // every output is a plain register bit
   assign o_rdata           = q_ff.rdata;
   assign o_dual_result     = q_ff.dres;
   assign o_dual_status_bad = q_ff.dbad;
   assign o_octal_result    = q_ff.ores;
   assign o_octal_status    = q_ff.ostat;

endmodule

// >>> logic_ops_pkg.sv
// constants, register map and carrier types of the configurable logic operators
package logic_ops_pkg;

   // register bus geometry, operand value width and octal input count
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VAL_W  = 16;
   localparam int NUM_IN = 8;

   // register byte offsets
   localparam logic [7:0] A_DUAL_CFG  = 8'h00;
   localparam logic [7:0] A_DUAL_OPA  = 8'h04;
   localparam logic [7:0] A_DUAL_OPB  = 8'h08;
   localparam logic [7:0] A_DUAL_HYST = 8'h0c;
   localparam logic [7:0] A_DUAL_OUT  = 8'h10;
   localparam logic [7:0] A_OCT_CFG   = 8'h14;
   localparam logic [7:0] A_OCT_IN    = 8'h18;
   localparam logic [7:0] A_OCT_OUT   = 8'h1c;

   // field positions
   localparam int F_OPD_BAD    = 16;
   localparam int F_OCT_BAD    = 8;
   localparam int F_OUT_BAD    = 1;
   localparam int F_OUT_ANYBAD = 8;
   localparam int F_OUT_STAT   = 16;

   // operand values are signed 8.8 fixed point; 0.5 is the logic threshold
   localparam logic signed [15:0] LOGIC_HALF = 16'h0080;

   // active input count limits of the octal gate
   localparam logic [3:0] OCT_MIN_IN = 4'h2;
   localparam logic [3:0] OCT_MAX_IN = 4'h8;

   typedef enum logic [3:0] {
      D_OFF, D_AND, D_OR, D_XOR, D_LATCH, D_EQ, D_NE, D_GT, D_LT, D_LE, D_GE
   } dual_op_t;

   typedef enum logic [1:0] {O_OFF, O_AND, O_OR, O_XOR} octal_op_t;

   // bit 0 is the forced result, bit 1 set means status stays healthy
   typedef enum logic [1:0] {
      POLICY_LOW_FAULTY, POLICY_HIGH_FAULTY, POLICY_LOW_HEALTHY, POLICY_HIGH_HEALTHY
   } fallback_t;

   typedef struct packed {
      logic      inv_b;
      logic      inv_a;
      fallback_t fallback;
      dual_op_t  op;
   } dual_cfg_t;

   typedef struct packed {
      logic [7:0] per_input_negate_mask;
      logic       spare;
      logic       out_negate;
      logic [3:0] count;
      octal_op_t  op;
   } octal_cfg_t;

   typedef struct packed {
      logic                    bad;
      logic signed [VAL_W-1:0] value;
   } operand_t;

   // reset values
   localparam dual_cfg_t  DUAL_CFG_RST = '{inv_b: 1'b0, inv_a: 1'b0,
      fallback: POLICY_LOW_FAULTY, op: D_OFF};
   localparam octal_cfg_t OCT_CFG_RST  = '{per_input_negate_mask: 8'h00, spare: 1'b0,
      out_negate: 1'b0, count: 4'h2, op: O_OFF};
   localparam operand_t   OPERAND_RST  = '{bad: 1'b0, value: 16'h0000};
   localparam logic [15:0] HYST_RST    = 16'h0000;

endpackage

// >>> logic_ops_props.sv
// assertion checker for the configurable logic operators
`timescale 1ns/1ps
module logic_ops_props (
   // clock and reset
   input wire logic                              i_clk,
   input wire logic                              i_rst,
   // register port
   input wire logic [logic_ops_pkg::ADDR_W-1:0]  i_addr,
   input wire logic [logic_ops_pkg::DATA_W-1:0]  i_wdata,
   input wire logic                              i_wr,
   input wire logic                              i_rd,
   input wire logic [logic_ops_pkg::DATA_W-1:0]  o_rdata,
   // results
   input wire logic                              o_dual_result,
   input wire logic                              o_dual_status_bad,
   input wire logic                              o_octal_result,
   input wire logic [logic_ops_pkg::NUM_IN:0]    o_octal_status
);
   import logic_ops_pkg::*;
   dual_cfg_t   dc_ff;
   operand_t    a_ff;
   operand_t    b_ff;
   octal_cfg_t  oc_ff;
   logic [15:0] oi_ff;
   logic [7:0]  m, lv, bm;
   logic [3:0]  n;
   logic        ox, oy, dx, gd, la, lb;
   // shadow of the writable registers except the band width, so results can be predicted from the bus alone
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dc_ff <= DUAL_CFG_RST;
         a_ff <= OPERAND_RST;
         b_ff <= OPERAND_RST;
         oc_ff <= OCT_CFG_RST;
         oi_ff <= 16'h0000;
      end else if (i_wr) begin
         if (i_addr == A_DUAL_CFG) dc_ff <= dual_cfg_t'(i_wdata[7:0]);
         if (i_addr == A_DUAL_OPA) a_ff <= operand_t'(i_wdata[16:0]);
         if (i_addr == A_DUAL_OPB) b_ff <= operand_t'(i_wdata[16:0]);
         if (i_addr == A_OCT_CFG) oc_ff <= octal_cfg_t'(i_wdata[15:0]);
         if (i_addr == A_OCT_IN) oi_ff <= i_wdata[15:0];
      end
   end
   always_comb begin
      n = (oc_ff.count < 4'h2) ? 4'h2 : ((oc_ff.count > 4'h8) ? 4'h8 : oc_ff.count);
      m = 8'((9'h001 << n) - 9'h001);
      lv = (oi_ff[7:0] ^ oc_ff.per_input_negate_mask) & m;
      bm = oi_ff[15:8] & m;
      case (oc_ff.op)
         O_AND: ox = &(lv | ~m);
         O_OR: ox = |lv;
         default: ox = ^lv;
      endcase
      oy = (oc_ff.op != O_OFF) && (ox ^ oc_ff.out_negate);
      gd = !a_ff.bad && !b_ff.bad;
      la = (a_ff.value >= LOGIC_HALF) ^ dc_ff.inv_a;
      lb = (b_ff.value >= LOGIC_HALF) ^ dc_ff.inv_b;
      case (dc_ff.op)
         D_AND: dx = la & lb;
         D_OR: dx = la | lb;
         D_XOR: dx = la ^ lb;
         default: dx = 1'b0;
      endcase
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_read_out;
      i_rd && i_addr == A_DUAL_OUT;
   endsequence
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data not idle");
   a_readback_out: assert property (s_read_out |=> o_rdata ==
      {30'h0000_0000, $past(o_dual_status_bad), $past(o_dual_result)})
      else $error("dual result readback wrong");
   a_oct_result: assert property (o_octal_result == $past(oy))
      else $error("octal result wrong");
   a_oct_status: assert property (o_octal_status == $past({|bm, bm}))
      else $error("octal status wrong");
   a_dual_fallback: assert property ($past(!gd) |-> o_dual_result == $past(dc_ff[4])
      && o_dual_status_bad == $past(!dc_ff[5])) else $error("fallback wrong");
   a_status_good: assert property ($past(gd) |-> !o_dual_status_bad)
      else $error("dual status bad with good operands");
   a_dual_logic: assert property ($past(gd && dc_ff.op inside {D_OFF, D_AND, D_OR, D_XOR})
      |-> o_dual_result == $past(dx)) else $error("dual logic wrong");
   a_dual_equal: assert property ($past(gd && dc_ff.op inside {D_EQ, D_NE}) |-> o_dual_result
      == $past((a_ff.value == b_ff.value) ^ (dc_ff.op == D_NE))) else $error("equal wrong");
endmodule

bind logic_ops logic_ops_props u_props (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .o_dual_result, .o_dual_status_bad, .o_octal_result, .o_octal_status);

// >>> tb_logic_ops.sv
// self-checking testbench of the configurable logic operators
`timescale 1ns/1ps
module tb_logic_ops;
   import logic_ops_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_dual_result, o_dual_status_bad, o_octal_result;
   logic [8:0]  o_octal_status;
   int          n_fail = 0;
   int          checks_done = 0;
   dual_op_t    ops [9] = '{D_AND, D_OR, D_XOR, D_EQ, D_NE, D_GT, D_LT, D_LE, D_GE};
   logic [15:0] vals [4] = '{16'h0000, 16'h007f, 16'h0080, 16'h0100};
   dual_cfg_t   c;
   operand_t    a, b;
   octal_cfg_t  oc;
   logic [15:0] ow;

   always #20 i_clk = ~i_clk;

   logic_ops dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_dual_result, .o_dual_status_bad, .o_octal_result, .o_octal_status);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= ad;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask
   // results follow a write by one extra edge
   task automatic step(input logic [7:0] ad, input logic [31:0] d, input logic r, input logic s);
      wr(ad, d);
      repeat (2) @(posedge i_clk);
      #1;
      chk(32'({o_dual_status_bad, o_dual_result}), 32'({s, r}));
   endtask
   task automatic end_of_test();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // compares use raw values; invert only touches logic levels
   function automatic logic dexp(dual_cfg_t k, operand_t p, operand_t q);
      logic la;
      logic lb;
      la = (p.value >= LOGIC_HALF) ^ k.inv_a;
      lb = (q.value >= LOGIC_HALF) ^ k.inv_b;
      case (k.op)
         D_AND: return la & lb;
         D_OR: return la | lb;
         D_XOR: return la ^ lb;
         D_EQ: return p.value == q.value;
         D_NE: return p.value != q.value;
         D_GT: return p.value > q.value;
         D_LT: return p.value < q.value;
         D_LE: return p.value <= q.value;
         D_GE: return p.value >= q.value;
         default: return 1'b0;
      endcase
   endfunction
   // octal gate: count clamped to two..eight, bit 0 of mask and levels is input one
   function automatic logic [31:0] oexp(octal_cfg_t k, logic [15:0] w);
      int         cnt;
      logic [7:0] lv;
      logic [7:0] bm;
      logic       x;
      cnt = int'(k.count);
      if (cnt < 2) cnt = 2;
      if (cnt > 8) cnt = 8;
      lv = '0;
      bm = '0;
      x = (k.op == O_AND);
      for (int i = 0; i < cnt; i++) begin
         lv[i] = w[i] ^ k.per_input_negate_mask[i];
         bm[i] = w[8 + i];
         if (k.op == O_AND) x = x & lv[i];
         if (k.op == O_OR) x = x | lv[i];
         if (k.op == O_XOR) x = x ^ lv[i];
      end
      return {22'h0, |bm, bm, (k.op != O_OFF) & (x ^ k.out_negate)};
   endfunction

   initial begin
      void'($urandom(64));
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(A_DUAL_CFG, 32'h0000_0000);
      rd(A_OCT_CFG, 32'h0000_0008);
      rd(8'h20, 32'h0000_0000);
      wr(A_DUAL_OUT, 32'h0000_0003);
      rd(A_DUAL_OUT, 32'h0000_0000);
      wr(A_DUAL_CFG, 32'(D_AND));
      wr(A_DUAL_OPB, 32'h0000_0080);
      step(A_DUAL_OPA, 32'h0000_0080, 1'b1, 1'b0);
      rd(A_DUAL_OUT, 32'h0000_0001);
      step(A_DUAL_OPA, 32'h0000_007f, 1'b0, 1'b0);
      step(A_DUAL_OPA, 32'h0000_ff80, 1'b0, 1'b0);
      for (int i = 0; i < 60; i++) begin
         c = '{inv_b: 1'($urandom), inv_a: 1'($urandom), fallback: POLICY_LOW_FAULTY,
            op: ops[$urandom % 9]};
         a = '{bad: 1'b0, value: vals[$urandom % 4]};
         b = '{bad: 1'b0, value: vals[$urandom % 4]};
         wr(A_DUAL_CFG, 32'(c));
         wr(A_DUAL_OPA, 32'(a));
         step(A_DUAL_OPB, 32'(b), dexp(c, a, b), 1'b0);
      end
      wr(A_DUAL_OPA, 32'h0001_0100);
      for (int p = 0; p < 4; p++) begin
         step(A_DUAL_CFG, 32'(p * 16 + int'(D_AND)), p[0], !p[1]);
      end
      wr(A_DUAL_HYST, 32'h0000_0100);
      wr(A_DUAL_OPB, 32'h0000_0200);
      wr(A_DUAL_OPA, 32'h0000_0300);
      step(A_DUAL_CFG, 32'(D_GT), 1'b1, 1'b0);
      step(A_DUAL_OPA, 32'h0000_0180, 1'b1, 1'b0);
      step(A_DUAL_OPA, 32'h0000_00f0, 1'b0, 1'b0);
      step(A_DUAL_OPA, 32'h0000_0180, 1'b0, 1'b0);
      step(A_DUAL_CFG, 32'(D_LATCH), 1'b1, 1'b0);
      step(A_DUAL_OPA, 32'h0000_0000, 1'b0, 1'b0);
      step(A_DUAL_OPB, 32'h0000_0000, 1'b0, 1'b0);
      step(A_DUAL_OPA, 32'h0000_0100, 1'b1, 1'b0);
      step(A_DUAL_OPA, 32'h0000_0000, 1'b1, 1'b0);
      step(A_DUAL_OPB, 32'h0000_0100, 1'b0, 1'b0);
      // all eight inputs high under a full-width conjunction, then random traffic
      wr(A_OCT_CFG, 32'h0000_0021);
      wr(A_OCT_IN, 32'h0000_00ff);
      repeat (2) @(posedge i_clk);
      #1;
      chk(32'({o_octal_status, o_octal_result}), 32'h0000_0001);
      rd(A_OCT_OUT, 32'h0000_0001);
      for (int i = 0; i < 80; i++) begin
         oc = octal_cfg_t'(16'($urandom) & 16'hff7f);
         ow = 16'($urandom);
         wr(A_OCT_CFG, 32'(oc));
         wr(A_OCT_IN, 32'(ow));
         repeat (2) @(posedge i_clk);
         #1;
         chk(32'({o_octal_status, o_octal_result}), oexp(oc, ow));
      end
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      end_of_test();
   end
endmodule
